// File: shared/buck_seq_map.vh
`ifndef BUCK_SEQ_MAP_VH
`define BUCK_SEQ_MAP_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_IRQ_STAT    12'h008
`define OFS_IRQ_MASK    12'h00c

// ****************************************
// control fields and reset values
// ****************************************
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET      1'b1
`define IRQ_MASK_RESET  5'h00

// ****************************************
// interrupt event bits
// ****************************************
`define EV_STANDBY      0
`define EV_RESTART      1
`define EV_LATCHED      2
`define EV_LIMIT_CYCLE  3
`define EV_SKIP         4
`define EV_COUNT        5

// ****************************************
// status fields
// ****************************************
`define ST_STATE_LSB    0
`define ST_MODE_LSB     4
`define ST_POR_BIT      6
`define ST_DIODE_BIT    7
`define ST_COUNT_LSB    8

// ****************************************
// restart modes, latched at power-on
// ****************************************
`define MODE_HICCUP     2'h0
`define MODE_NOHICCUP   2'h1
`define MODE_LATCHOFF   2'h2

// ****************************************
// fault counting
// ****************************************
`define FAULT_TRIP      256
`define FAULT_WIDTH     9

`endif

// File: core/fault_run_counter.v
`include "buck_seq_map.vh"
`default_nettype none

module fault_run_counter #(
  parameter WIDTH = `FAULT_WIDTH,
  parameter LIMIT = `FAULT_TRIP
) (
  input  wire             clk_i,
  input  wire             srst_i,
  input  wire             clear_i,
  input  wire             step_i,
  output wire [WIDTH-1:0] count_o,
  output wire             trip_o
);

  localparam [WIDTH-1:0] LIMIT_W = LIMIT[WIDTH-1:0];

  reg [WIDTH-1:0] count_reg;

  // ****************************************
  // run length of limited cycles, saturating
  // ****************************************
  always @(posedge clk_i) begin
    if (srst_i || clear_i) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (step_i && (count_reg != LIMIT_W)) begin
      count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign count_o = count_reg;
  assign trip_o  = (count_reg == LIMIT_W);

endmodule

`default_nettype wire

// File: core/buck_fault_mode_sequencer.v
// Added by the designer: the address map and the APB register port.
`include "buck_seq_map.vh"
`default_nettype none

module buck_fault_mode_sequencer (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        pwm_clk_i,
  input  wire        bias_ok_i,
  input  wire        line_undervoltage_input_i,
  input  wire        line_shutdown_i,
  input  wire        restart_node_high_i,
  input  wire        restart_node_grounded_i,
  input  wire        ramp_over_limit_i,
  input  wire        pwm_cmp_trip_i,
  input  wire        sample_over_limit_i,
  input  wire        switch_node_above_i,
  input  wire        diode_emul_select_i,
  input  wire        soft_start_low_i,
  output wire        high_gate_drive_o,
  output wire        low_gate_drive_o,
  output wire        sample_hold_o,
  output wire        ramp_discharge_o,
  output wire        ss_discharge_o,
  output wire        restart_charge_o,
  output wire        restart_discharge_o,
  output wire        standby_o,
  output wire        diode_emul_active_o,
  output wire        irq_o
);

  localparam [3:0] S_OFF   = 4'h1;
  localparam [3:0] S_RUN   = 4'h2;
  localparam [3:0] S_STBY  = 4'h4;
  localparam [3:0] S_LATCH = 4'h8;

  // ****************************************
  // state
  // ****************************************
  reg  [3:0]              state_reg;
  reg  [3:0]              state_next;
  reg  [1:0]              mode_reg;
  reg                     por_done_reg;
  reg                     pwm_clk_d_reg;
  reg                     sample_reg;
  reg                     high_on_reg;
  reg                     cl_cycle_reg;
  reg                     high_reg;
  reg                     low_reg;
  reg                     ramp_dis_reg;
  reg                     ss_dis_reg;
  reg                     rnode_chg_reg;
  reg                     rnode_dis_reg;
  reg                     ctrl_en_reg;
  reg  [`EV_COUNT-1:0]    irq_stat_reg;
  reg  [`EV_COUNT-1:0]    irq_mask_reg;
  reg  [31:0]             prdata_reg;
  reg  [`EV_COUNT-1:0]    ev;
  reg                     high_on_next;
  reg                     cl_cycle_next;
  reg                     cnt_step;
  reg                     cnt_clear;
  reg  [31:0]             rd_mux;
  reg                     addr_ok;

  wire                    pwm_edge;
  wire                    power_ok;
  wire                    run_ok;
  wire                    diode_active;
  wire                    trip;
  wire [`FAULT_WIDTH-1:0] count;
  wire                    wr_en;
  wire                    setup;
  wire                    run_next;

  assign pwm_edge     = pwm_clk_i & ~pwm_clk_d_reg;
  assign power_ok     = bias_ok_i & line_undervoltage_input_i;
  assign run_ok       = power_ok & por_done_reg & ctrl_en_reg;
  // select high means continuous conduction unless soft_start_low_i forces emulation; low or open means emulation
  assign diode_active = ~diode_emul_select_i | soft_start_low_i;
  assign run_next     = (state_next == S_RUN);

  fault_run_counter #(
    .WIDTH (`FAULT_WIDTH),
    .LIMIT (`FAULT_TRIP)
  ) u_fault_cnt (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .clear_i (cnt_clear),
    .step_i  (cnt_step),
    .count_o (count),
    .trip_o  (trip)
  );

  // ****************************************
  // power-on mode latch
  // ****************************************
  always @(posedge clk_i) begin
    if (srst_i) begin
      por_done_reg <= 1'b0;
      mode_reg     <= `MODE_HICCUP;
    end else if (power_ok && !por_done_reg) begin
      por_done_reg <= 1'b1;
      if (restart_node_high_i) begin
        mode_reg <= `MODE_NOHICCUP;
      end else if (restart_node_grounded_i) begin
        mode_reg <= `MODE_LATCHOFF;
      end else begin
        mode_reg <= `MODE_HICCUP;
      end
    end
  end

  // ****************************************
  // cycle and fault sequencing
  // ****************************************
  always @* begin
    state_next    = state_reg;
    high_on_next  = high_on_reg;
    cl_cycle_next = cl_cycle_reg;
    cnt_step      = 1'b0;
    cnt_clear     = 1'b0;
    ev            = {`EV_COUNT{1'b0}};
    case (state_reg)
      S_OFF: begin
        cnt_clear    = 1'b1;
        high_on_next = 1'b0;
        if (run_ok) begin
          state_next    = S_RUN;
          cl_cycle_next = 1'b0;
        end
      end
      S_RUN: begin
        if (!run_ok) begin
          state_next   = S_OFF;
          high_on_next = 1'b0;
        end else if (pwm_edge) begin
          high_on_next = 1'b0;
          if (cl_cycle_reg) begin
            cnt_step             = 1'b1;
            ev[`EV_LIMIT_CYCLE]  = 1'b1;
          end else begin
            cnt_clear = 1'b1;
          end
        end else if (sample_reg) begin
          // sampled recirculating current decides this pulse
          if (sample_over_limit_i) begin
            high_on_next  = 1'b0;
            cl_cycle_next = 1'b1;
            ev[`EV_SKIP]  = 1'b1;
          end else begin
            high_on_next  = 1'b1;
            cl_cycle_next = 1'b0;
          end
        end else if (high_on_reg) begin
          if (ramp_over_limit_i) begin
            high_on_next  = 1'b0;
            cl_cycle_next = 1'b1;
          end else if (pwm_cmp_trip_i) begin
            high_on_next = 1'b0;
          end
        end
        if (trip && (mode_reg != `MODE_NOHICCUP) && run_ok) begin
          high_on_next = 1'b0;
          cnt_clear    = 1'b1;
          if (mode_reg == `MODE_LATCHOFF) begin
            state_next       = S_LATCH;
            ev[`EV_LATCHED]  = 1'b1;
          end else begin
            state_next       = S_STBY;
            ev[`EV_STANDBY]  = 1'b1;
          end
        end
      end
      S_STBY: begin
        cnt_clear    = 1'b1;
        high_on_next = 1'b0;
        if (!power_ok) begin
          state_next = S_OFF;
        end else if (restart_node_high_i) begin
          state_next      = S_OFF;
          ev[`EV_RESTART] = 1'b1;
        end
      end
      S_LATCH: begin
        cnt_clear    = 1'b1;
        high_on_next = 1'b0;
        if (line_shutdown_i) begin
          state_next = S_OFF;
        end
      end
      default: begin
        state_next   = S_OFF;
        high_on_next = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      state_reg     <= S_OFF;
      pwm_clk_d_reg <= 1'b0;
      sample_reg    <= 1'b0;
      high_on_reg   <= 1'b0;
      cl_cycle_reg  <= 1'b0;
      high_reg      <= 1'b0;
      low_reg       <= 1'b0;
      ramp_dis_reg  <= 1'b1;
      ss_dis_reg    <= 1'b1;
      rnode_chg_reg <= 1'b0;
      rnode_dis_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      pwm_clk_d_reg <= pwm_clk_i;
      // one clock of sampling right before the high-side interval
      sample_reg    <= run_next && pwm_edge && (state_reg == S_RUN);
      high_on_reg   <= high_on_next;
      cl_cycle_reg  <= cl_cycle_next;
      high_reg      <= run_next & high_on_next;
      low_reg       <= run_next & ~high_on_next &
                       ~(diode_active & switch_node_above_i);
      ramp_dis_reg  <= ~(run_next & high_on_next);
      ss_dis_reg    <= ~run_next;
      rnode_chg_reg <= (state_next == S_STBY);
      rnode_dis_reg <= (mode_reg == `MODE_HICCUP) &&
                       (state_next != S_STBY);
    end
  end

  assign high_gate_drive_o   = high_reg;
  assign low_gate_drive_o    = low_reg;
  assign sample_hold_o       = sample_reg;
  assign ramp_discharge_o    = ramp_dis_reg;
  assign ss_discharge_o      = ss_dis_reg;
  assign restart_charge_o    = rnode_chg_reg;
  assign restart_discharge_o = rnode_dis_reg;
  assign standby_o           = (state_reg == S_STBY) | (state_reg == S_LATCH);
  assign diode_emul_active_o = diode_active;

  // ****************************************
  // apb slave
  // ****************************************
  assign setup = psel_i & ~penable_i;
  assign wr_en = psel_i & penable_i & pwrite_i & addr_ok;

  always @* begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr_i)
      `OFS_CTRL: begin
        rd_mux[`CTRL_ENABLE_BIT] = ctrl_en_reg;
      end
      `OFS_STATUS: begin
        rd_mux[`ST_STATE_LSB+3:`ST_STATE_LSB]               = state_reg;
        rd_mux[`ST_MODE_LSB+1:`ST_MODE_LSB]                 = mode_reg;
        rd_mux[`ST_POR_BIT]                                 = por_done_reg;
        rd_mux[`ST_DIODE_BIT]                               = diode_active;
        rd_mux[`ST_COUNT_LSB+`FAULT_WIDTH-1:`ST_COUNT_LSB]  = count;
      end
      `OFS_IRQ_STAT: begin
        rd_mux[`EV_COUNT-1:0] = irq_stat_reg;
      end
      `OFS_IRQ_MASK: begin
        rd_mux[`EV_COUNT-1:0] = irq_mask_reg;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_en_reg  <= `CTRL_RESET;
      irq_mask_reg <= `IRQ_MASK_RESET;
      irq_stat_reg <= {`EV_COUNT{1'b0}};
      prdata_reg   <= 32'h0000_0000;
    end else begin
      if (setup && !pwrite_i) begin
        prdata_reg <= rd_mux;
      end
      if (wr_en && (paddr_i == `OFS_CTRL)) begin
        ctrl_en_reg <= pwdata_i[`CTRL_ENABLE_BIT];
      end
      if (wr_en && (paddr_i == `OFS_IRQ_MASK)) begin
        irq_mask_reg <= pwdata_i[`EV_COUNT-1:0];
      end
      // new events win over a write-one-to-clear in the same cycle
      if (wr_en && (paddr_i == `OFS_IRQ_STAT)) begin
        irq_stat_reg <= (irq_stat_reg & ~pwdata_i[`EV_COUNT-1:0]) | ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev;
      end
    end
  end

  assign prdata_o  = prdata_reg;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign irq_o     = |(irq_stat_reg & irq_mask_reg);

endmodule

`default_nettype wire

// File: verification/buck_seq_props.sv
`default_nettype none
module buck_seq_props (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic high_gate_drive_o,
  input wire logic low_gate_drive_o,
  input wire logic standby_o,
  input wire logic ss_discharge_o,
  input wire logic ramp_discharge_o,
  input wire logic ramp_over_limit_i,
  input wire logic pwm_cmp_trip_i,
  input wire logic sample_hold_o,
  input wire logic sample_over_limit_i,
  input wire logic diode_emul_active_o,
  input wire logic diode_emul_select_i,
  input wire logic switch_node_above_i,
  input wire logic soft_start_low_i,
  input wire logic bias_ok_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence skip_seen;
    sample_hold_o && sample_over_limit_i;
  endsequence
  sequence high_starts;
    $rose(high_gate_drive_o);
  endsequence
  AST_STBY_OFF: assert property (standby_o && $past(standby_o) |->
    !high_gate_drive_o && !low_gate_drive_o && ss_discharge_o) else $error("drive in standby");
  AST_RAMP_END: assert property (high_gate_drive_o && ramp_over_limit_i |=>
    !high_gate_drive_o) else $error("ramp limit ignored");
  AST_CMP_END: assert property (high_gate_drive_o && pwm_cmp_trip_i |=>
    !high_gate_drive_o) else $error("pwm trip ignored");
  AST_SKIP: assert property (skip_seen |=> !high_gate_drive_o [*2])
    else $error("pulse not skipped");
  AST_SAMPLE: assert property (high_starts |-> $past(sample_hold_o))
    else $error("no sample before turn-on");
  AST_RAMP_DIS: assert property (!high_gate_drive_o |->
    ramp_discharge_o) else $error("ramp not discharged");
  AST_DIODE: assert property (diode_emul_active_o && switch_node_above_i |=>
    !low_gate_drive_o) else $error("reverse current allowed");
  AST_SEL: assert property (!diode_emul_select_i && !ss_discharge_o |->
    diode_emul_active_o) else $error("select ignored");
  AST_FORCE: assert property (soft_start_low_i && !ss_discharge_o |->
    diode_emul_active_o) else $error("soft-start force missing");
  AST_BIAS: assert property (!bias_ok_i [*2] |=> !high_gate_drive_o && !low_gate_drive_o)
    else $error("drive without bias");
endmodule
bind buck_fault_mode_sequencer buck_seq_props u_props (.*);
`default_nettype wire

// File: verification/buck_partner.sv
`default_nettype none
module buck_partner #(parameter int PER = 16) (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic high_i,
  input  wire logic limit_i,
  input  wire logic skip_i,
  output logic      pwm_clk_o,
  output logic      ramp_over_o,
  output logic      cmp_trip_o,
  output logic      sample_over_o,
  output logic      node_above_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic [7:0] hcnt;
  always @(posedge clk_i) begin
    cnt <= (srst_i || cnt == 8'(PER - 1)) ? 8'h00 : cnt + 8'h01;
    hcnt <= (high_i === 1'b1) ? hcnt + 8'h01 : 8'h00;
  end
  assign pwm_clk_o = (cnt == 8'h01);
  assign ramp_over_o = high_i && limit_i && hcnt >= 8'h02;
  assign cmp_trip_o = high_i && hcnt >= 8'h05;
  assign sample_over_o = skip_i;
  // released switch node rings, never holds a level
  assign node_above_o = high_i | cnt[0];
endmodule
`default_nettype wire

// File: verification/tb.sv
`include "buck_seq_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, srst_i = 1, psel = 0, pen = 0, pwr = 0, bias = 0, line = 0, shut = 0;
  logic nhi = 0, ngnd = 0, sel = 0, ssl = 0, limit = 0, skip = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q, seed = 32'hce2d, prdata;
  logic pready, pslverr, hi, ld, sh, rdis, ssd, rc, rsd, stby, dea, irq, pwm, rov, cmp, sov, swa;
  int bad_count = 0, total_checks = 0;
  buck_fault_mode_sequencer dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pwm_clk_i(pwm), .bias_ok_i(bias),
    .line_undervoltage_input_i(line), .line_shutdown_i(shut), .restart_node_high_i(nhi),
    .restart_node_grounded_i(ngnd), .ramp_over_limit_i(rov), .pwm_cmp_trip_i(cmp),
    .sample_over_limit_i(sov), .switch_node_above_i(swa), .diode_emul_select_i(sel),
    .soft_start_low_i(ssl), .high_gate_drive_o(hi), .low_gate_drive_o(ld), .sample_hold_o(sh),
    .ramp_discharge_o(rdis), .ss_discharge_o(ssd), .restart_charge_o(rc),
    .restart_discharge_o(rsd), .standby_o(stby), .diode_emul_active_o(dea), .irq_o(irq));
  buck_partner #(.PER(16)) ext (.clk_i(clk_i), .srst_i(srst_i), .high_i(hi), .limit_i(limit),
    .skip_i(skip), .pwm_clk_o(pwm), .ramp_over_o(rov), .cmp_trip_o(cmp), .sample_over_o(sov),
    .node_above_o(swa));
  initial forever #12.5 clk_i = ~clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] exp_mode(input logic h, input logic g);
    return h ? `MODE_NOHICCUP : (g ? `MODE_LATCHOFF : `MODE_HICCUP);
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    pen <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      chk("pready", 1, 0);
      conclude();
    end
    q = prdata;
    err = pslverr;
    psel <= 0; pen <= 0;
  endtask
  task automatic cyc(input int n);
    repeat (n * 16) @(posedge clk_i);
  endtask
  task automatic wait_stby(input logic w, input int lim);
    for (int i = 0; i < lim && stby !== w; i++) @(posedge clk_i);
    chk("standby", {31'h0, w}, {31'h0, stby});
    if (stby !== w) conclude();
  endtask
  task automatic power_on(input logic h, input logic g);
    srst_i <= 1; nhi <= h; ngnd <= g; bias <= 0; line <= 0; shut <= 0; limit <= 0; skip <= 0;
    repeat (2) @(posedge clk_i);
    srst_i <= 0;
    repeat (3) @(posedge clk_i);
    bias <= 1; line <= 1;
    apb(0, `OFS_STATUS, 0);
    chk("mode", {30'h0, exp_mode(h, g)}, {30'h0, q[5:4]});
    chk("mode_latched", 1, {31'h0, q[`ST_POR_BIT]});
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    power_on(0, 0);
    repeat (40) begin
      q = rnd();
      limit <= q[0];
      skip <= q[1] & q[2];
      sel <= q[3];
      ssl <= q[4];
      cyc(1);
    end
    limit <= 0; skip <= 0;
    cyc(3);
    apb(0, `OFS_STATUS, 0);
    chk("count", 0, {23'h0, q[16:8]});
    limit <= 1; cyc(240); limit <= 0; cyc(2); limit <= 1; cyc(250);
    chk("standby_early", 0, {31'h0, stby});
    wait_stby(1, 16 * 12);
    chk("restart_charge", 1, {31'h0, rc});
    chk("restart_discharge_stby", 0, {31'h0, rsd});
    chk("ss_discharge", 1, {31'h0, ssd});
    apb(0, `OFS_IRQ_STAT, 0);
    chk("irq_stat", 1, {31'h0, q[`EV_STANDBY]});
    apb(1, `OFS_IRQ_MASK, 32'h1);
    @(posedge clk_i);
    chk("irq_on", 1, {31'h0, irq});
    apb(1, `OFS_IRQ_STAT, 32'h1);
    @(posedge clk_i);
    chk("irq_off", 0, {31'h0, irq});
    nhi <= 1;
    wait_stby(0, 100);
    chk("restart_discharge", 1, {31'h0, rsd});
    nhi <= 0;
    apb(0, `OFS_STATUS, 0);
    chk("mode_kept", 0, {30'h0, q[5:4]});
    apb(0, 12'h010, 0);
    chk("unmapped_err", 1, {31'h0, err});
    chk("unmapped_data", 0, q);
    power_on(0, 1);
    limit <= 1;
    cyc(250);
    wait_stby(1, 16 * 12);
    nhi <= 1; cyc(5);
    chk("latched", 1, {31'h0, stby});
    shut <= 1;
    wait_stby(0, 100);
    power_on(1, 0);
    limit <= 1;
    cyc(300);
    chk("no_hiccup", 0, {31'h0, stby});
    apb(1, `OFS_CTRL, 32'h0);
    apb(0, `OFS_STATUS, 0);
    chk("ctrl_off_state", 1, {28'h0, q[3:0]});
    chk("ctrl_off_high", 0, {31'h0, hi});
    conclude();
  end
endmodule
`default_nettype wire
